// >>> i2cse_pkg.sv
// Constants, status codes and state type of the two-wire status engine
package i2cse_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned T_HALF_NS     = 5000;
  localparam int unsigned HALF_CYC      = (T_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_SET = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_DATA     = 8'h08;
  localparam logic [7:0] OFS_CTRL_CLR = 8'h0C;
  localparam logic [7:0] OFS_OWN_ADDR = 8'h10;

  // ------------------------------------------------------------
  // Control bit positions
  // ------------------------------------------------------------
  localparam int unsigned CB_ACK   = 2;
  localparam int unsigned CB_FLAG  = 3;
  localparam int unsigned CB_END   = 4;
  localparam int unsigned CB_BEGIN = 5;
  localparam int unsigned CB_EN    = 6;

  // ------------------------------------------------------------
  // Status codes
  // ------------------------------------------------------------
  localparam logic [7:0] SC_BUS_ERR    = 8'h00;
  localparam logic [7:0] SC_START      = 8'h08;
  localparam logic [7:0] SC_RSTART     = 8'h10;
  localparam logic [7:0] SC_MT_AW_ACK  = 8'h18;
  localparam logic [7:0] SC_MT_AW_NACK = 8'h20;
  localparam logic [7:0] SC_MT_D_ACK   = 8'h28;
  localparam logic [7:0] SC_MT_D_NACK  = 8'h30;
  localparam logic [7:0] SC_ARB_LOST   = 8'h38;
  localparam logic [7:0] SC_MR_AR_ACK  = 8'h40;
  localparam logic [7:0] SC_MR_AR_NACK = 8'h48;
  localparam logic [7:0] SC_MR_D_ACK   = 8'h50;
  localparam logic [7:0] SC_MR_D_NACK  = 8'h58;
  localparam logic [7:0] SC_SR_OWN     = 8'h60;
  localparam logic [7:0] SC_SR_OWN_AL  = 8'h68;
  localparam logic [7:0] SC_SR_GC      = 8'h70;
  localparam logic [7:0] SC_SR_GC_AL   = 8'h78;
  localparam logic [7:0] SC_SR_D_ACK   = 8'h80;
  localparam logic [7:0] SC_SR_D_NACK  = 8'h88;
  localparam logic [7:0] SC_SR_G_ACK   = 8'h90;
  localparam logic [7:0] SC_SR_G_NACK  = 8'h98;
  localparam logic [7:0] SC_SR_STOP    = 8'hA0;
  localparam logic [7:0] SC_ST_OWN     = 8'hA8;
  localparam logic [7:0] SC_ST_OWN_AL  = 8'hB0;
  localparam logic [7:0] SC_ST_D_ACK   = 8'hB8;
  localparam logic [7:0] SC_ST_D_NACK  = 8'hC0;
  localparam logic [7:0] SC_ST_LAST    = 8'hC8;
  localparam logic [7:0] SC_IDLE       = 8'hF8;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_STATUS = SC_IDLE;
  localparam logic [7:0] RST_DATA   = 8'h00;
  localparam logic [7:0] RST_OWN    = 8'h00;

  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_RS_LOW, ST_RS_HIGH, ST_LOW, ST_HIGH,
    ST_HOLD, ST_SLOT, ST_STOP_LOW, ST_STOP_HIGH
  } i2cse_state_e;

endpackage

// >>> i2cse_core.sv
// Byte-level status engine of a two-wire bus controller
//
// Notes on behaviour
// - After own START report 0x08, then send address byte, sample acknowledge.
// - Address+write acked: report 0x18, then send the buffered data byte.
// - Address+write not acked: report 0x20.
// - Misplaced START/STOP while involved: release lines, unaddressed, flag, 0x00.
// - Sent data acked: report 0x28, then next byte or STOP if requested.
// - Sent data not acked: report 0x30, STOP once requested and flag cleared.
// - Arbitration lost in address or data: 0x38, release; no restart unless begin is set again.
// - Address+read acked: report 0x40, receive byte, ack if ack-enable set.
// - Address+read not acked: report 0x48.
// - Master byte received and acked: 0x50; next ack follows ack-enable.
// - Master byte received, NOT ACK returned: 0x58, byte in buffer.
// - Own address+write acked: 0x60, continue as slave receiver.
// - Addressed after lost arbitration: 0x68, 0x78 or 0xB0; START does not pend.
// - General call acked: 0x70, continue as slave receiver.
// - Own-addressed byte acked: 0x80; next ack only while ack-enable set.
// - Own-addressed byte with NOT ACK: 0x88, become unaddressed.
// - General call byte acked: 0x90; later bytes NOT ACK when cleared.
// - General call byte with NOT ACK: 0x98, become unaddressed.
// - STOP or repeated START while addressed: 0xA0, become unaddressed.
// - Own address+read acked: 0xA8, transmit the buffered byte.
// - Slave sent byte acked: 0xB8; not acked: 0xC0 and unaddressed.
// - Last slave byte with ack-enable clear, acked: 0xC8, unaddressed.
// - Control-set writes 0x04, 0x14, 0x24 set bits; zero bits untouched.
// - Control-clear 0x08 clears flag; 0x0C clears flag and ack-enable.
//
// Our own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module i2cse_core
  import i2cse_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = HALF_CYC
)
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       srst,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Bus pins
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe
);

  i2cse_state_e state_ff;
  logic [1:0]   sync1_ff;
  logic [1:0]   sync2_ff;
  logic [1:0]   prev_ff;
  logic [15:0]  timer_ff;
  logic [3:0]   bit_cnt_ff;
  logic [7:0]   data_ff;
  logic [7:0]   status_ff;
  logic [7:0]   own_addr_ff;
  logic [7:0]   rdata_ff;
  logic         flag_ff;
  logic         ack_en_ff;
  logic         end_req_ff;
  logic         begin_req_ff;
  logic         enable_ff;
  logic         is_master_ff;
  logic         addressed_ff;
  logic         gc_ff;
  logic         addr_phase_ff;
  logic         tx_dir_ff;
  logic         rw_ff;
  logic         arb_lost_ff;
  logic         rstart_ff;
  logic         ack_ff;
  logic         sample_ff;
  logic         busy_ff;
  logic         slot_armed_ff;
  logic         scl_oe_ff;
  logic         sda_oe_ff;
  logic         nxt_scl_oe;
  logic         nxt_sda_oe;
  logic         slot_drive;
  logic         scl_s;
  logic         sda_s;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;
  logic         bus_cond;
  logic         bus_err;
  logic         half_done;
  logic         arb_hit;
  logic         slv_end;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_sync
    always_ff @(posedge core_clk)
    begin
      if (srst)
      begin
        sync1_ff[i] <= 1'b1;
        sync2_ff[i] <= 1'b1;
        prev_ff[i]  <= 1'b1;
      end
      else
      begin
        sync1_ff[i] <= (i == 0) ? scl_in : sda_in;
        sync2_ff[i] <= sync1_ff[i];
        prev_ff[i]  <= sync2_ff[i];
      end
    end
  end

  assign scl_s     = sync2_ff[0];
  assign sda_s     = sync2_ff[1];
  assign scl_rise  = scl_s & ~prev_ff[0];
  assign scl_fall  = ~scl_s & prev_ff[0];
  assign start_det = scl_s & prev_ff[0] & prev_ff[1] & ~sda_s;
  assign stop_det  = scl_s & prev_ff[0] & ~prev_ff[1] & sda_s;
  assign bus_cond  = start_det | stop_det;
  assign half_done = timer_ff >= 16'(HALF_CYCLES - 1);

  assign bus_err = bus_cond && (state_ff == ST_LOW || state_ff == ST_HIGH ||
                   (state_ff == ST_SLOT && addressed_ff && bit_cnt_ff != 4'h0));
  assign arb_hit = state_ff == ST_HIGH && scl_s && half_done && !bit_cnt_ff[3] &&
                   tx_dir_ff && data_ff[7] && !sda_s && !bus_cond;
  assign slv_end = state_ff == ST_SLOT && scl_fall && bit_cnt_ff == 4'h8 && !bus_cond;

  // ------------------------------------------------------------
  // Bus busy tracking
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
      busy_ff <= 1'b0;
    else if (start_det)
      busy_ff <= 1'b1;
    else if (stop_det)
      busy_ff <= 1'b0;
  end

  // ------------------------------------------------------------
  // Slot arming: first falling clock after START carries no bit
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
      slot_armed_ff <= 1'b0;
    else if (start_det)
      slot_armed_ff <= 1'b0;
    else if (scl_rise)
      slot_armed_ff <= 1'b1;
  end

  // ------------------------------------------------------------
  // Engine: control bits, byte shifting, status and flag
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_ff      <= ST_IDLE;
      timer_ff      <= 16'h0000;
      bit_cnt_ff    <= 4'h0;
      data_ff       <= RST_DATA;
      status_ff     <= RST_STATUS;
      own_addr_ff   <= RST_OWN;
      flag_ff       <= 1'b0;
      ack_en_ff     <= 1'b0;
      end_req_ff    <= 1'b0;
      begin_req_ff  <= 1'b0;
      enable_ff     <= 1'b0;
      is_master_ff  <= 1'b0;
      addressed_ff  <= 1'b0;
      gc_ff         <= 1'b0;
      addr_phase_ff <= 1'b0;
      tx_dir_ff     <= 1'b0;
      rw_ff         <= 1'b0;
      arb_lost_ff   <= 1'b0;
      rstart_ff     <= 1'b0;
      ack_ff        <= 1'b0;
      sample_ff     <= 1'b1;
    end
    else
    begin
      // set port sets only written ones
      if (reg_wr && reg_addr == OFS_CTRL_SET)
      begin
        if (reg_wdata[CB_ACK])   ack_en_ff    <= 1'b1;
        if (reg_wdata[CB_END])   end_req_ff   <= 1'b1;
        if (reg_wdata[CB_BEGIN]) begin_req_ff <= 1'b1;
        if (reg_wdata[CB_EN])    enable_ff    <= 1'b1;
      end
      // clear port; hardware sets below win
      if (reg_wr && reg_addr == OFS_CTRL_CLR)
      begin
        if (reg_wdata[CB_FLAG])  flag_ff      <= 1'b0;
        if (reg_wdata[CB_ACK])   ack_en_ff    <= 1'b0;
        if (reg_wdata[CB_BEGIN]) begin_req_ff <= 1'b0;
        if (reg_wdata[CB_EN])    enable_ff    <= 1'b0;
      end
      if (reg_wr && reg_addr == OFS_DATA)
        data_ff <= reg_wdata;
      if (reg_wr && reg_addr == OFS_OWN_ADDR)
        own_addr_ff <= reg_wdata;
      timer_ff <= timer_ff + 16'h0001;

      unique case (state_ff)
        ST_IDLE:
        begin
          is_master_ff <= 1'b0;
          if (!enable_ff)
            rstart_ff <= 1'b0;
          else if (end_req_ff && !flag_ff)
            end_req_ff <= 1'b0;
          // pending START once bus is free
          else if (begin_req_ff && !flag_ff && !busy_ff)
          begin
            state_ff     <= ST_START;
            timer_ff     <= 16'h0000;
            is_master_ff <= 1'b1;
            begin_req_ff <= 1'b0;
            rstart_ff    <= 1'b0;
          end
          else if (start_det)
          begin
            state_ff      <= ST_SLOT;
            bit_cnt_ff    <= 4'h0;
            addr_phase_ff <= 1'b1;
            addressed_ff  <= 1'b0;
            tx_dir_ff     <= 1'b0;
            arb_lost_ff   <= 1'b0;
          end
        end
        ST_START:
          if (half_done)
          begin
            state_ff      <= ST_HOLD;
            status_ff     <= rstart_ff ? SC_RSTART : SC_START;
            flag_ff       <= 1'b1;
            addr_phase_ff <= 1'b1;
            arb_lost_ff   <= 1'b0;
          end
        ST_RS_LOW:
          if (half_done)
          begin
            state_ff <= ST_RS_HIGH;
            timer_ff <= 16'h0000;
          end
        ST_RS_HIGH:
          if (!scl_s)
            timer_ff <= 16'h0000;
          else if (half_done)
          begin
            state_ff  <= ST_START;
            timer_ff  <= 16'h0000;
            rstart_ff <= 1'b1;
          end
        ST_LOW:
          if (half_done)
          begin
            state_ff <= ST_HIGH;
            timer_ff <= 16'h0000;
          end
        ST_HIGH:
          if (!scl_s)
            timer_ff <= 16'h0000;
          else if (half_done && !bit_cnt_ff[3])
          begin
            data_ff <= {data_ff[6:0], sda_s};
            if (arb_hit)
            begin
              is_master_ff <= 1'b0;
              arb_lost_ff  <= 1'b1;
              tx_dir_ff    <= 1'b0;
              if (addr_phase_ff)
                state_ff <= ST_SLOT;
              else
              begin
                state_ff  <= ST_IDLE;
                status_ff <= SC_ARB_LOST;
                flag_ff   <= 1'b1;
              end
            end
            else
            begin
              // ack of next byte follows ack-enable
              if (bit_cnt_ff == 4'h7)
                ack_ff <= ack_en_ff;
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              state_ff   <= ST_LOW;
              timer_ff   <= 16'h0000;
            end
          end
          else if (half_done)
          begin
            state_ff      <= ST_HOLD;
            flag_ff       <= 1'b1;
            addr_phase_ff <= 1'b0;
            if (addr_phase_ff)
              status_ff <= rw_ff ? (sda_s ? SC_MR_AR_NACK : SC_MR_AR_ACK)
                                 : (sda_s ? SC_MT_AW_NACK : SC_MT_AW_ACK);
            else if (tx_dir_ff)
              status_ff <= sda_s ? SC_MT_D_NACK : SC_MT_D_ACK;
            else
              status_ff <= ack_ff ? SC_MR_D_ACK : SC_MR_D_NACK;
          end
        // clock held low until flag clears
        ST_HOLD:
          if (!flag_ff)
          begin
            timer_ff   <= 16'h0000;
            bit_cnt_ff <= 4'h0;
            if (!is_master_ff)
              state_ff <= ST_SLOT;
            else if (end_req_ff)
              state_ff <= ST_STOP_LOW;
            else if (begin_req_ff)
            begin
              state_ff     <= ST_RS_LOW;
              begin_req_ff <= 1'b0;
            end
            else
            begin
              state_ff  <= ST_LOW;
              tx_dir_ff <= addr_phase_ff | ~rw_ff;
              if (addr_phase_ff)
                rw_ff <= data_ff[0];
            end
          end
        ST_SLOT:
        begin
          if (scl_rise && !bit_cnt_ff[3])
            data_ff <= {data_ff[6:0], sda_s};
          if (scl_rise && bit_cnt_ff[3])
            sample_ff <= sda_s;
          if (scl_fall && slot_armed_ff && !bit_cnt_ff[3])
          begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == 4'h7 && addr_phase_ff)
            begin
              gc_ff  <= data_ff == 8'h00 && own_addr_ff[0];
              rw_ff  <= data_ff[0];
              ack_ff <= ack_en_ff && ((data_ff[7:1] == own_addr_ff[7:1] && data_ff != 8'h00) ||
                                      (data_ff == 8'h00 && own_addr_ff[0]));
            end
            else if (bit_cnt_ff == 4'h7)
              ack_ff <= ack_en_ff;
          end
          if (slv_end)
          begin
            bit_cnt_ff <= 4'h0;
            state_ff   <= ST_HOLD;
            flag_ff    <= 1'b1;
            if (addr_phase_ff)
            begin
              addr_phase_ff <= 1'b0;
              if (ack_ff)
              begin
                addressed_ff <= 1'b1;
                tx_dir_ff    <= rw_ff;
                if (rw_ff)
                  status_ff <= arb_lost_ff ? SC_ST_OWN_AL : SC_ST_OWN;
                else if (gc_ff)
                  status_ff <= arb_lost_ff ? SC_SR_GC_AL : SC_SR_GC;
                else
                  status_ff <= arb_lost_ff ? SC_SR_OWN_AL : SC_SR_OWN;
              end
              else
              begin
                state_ff  <= ST_IDLE;
                flag_ff   <= arb_lost_ff;
                status_ff <= arb_lost_ff ? SC_ARB_LOST : status_ff;
              end
            end
            else if (tx_dir_ff)
            begin
              status_ff <= sample_ff ? SC_ST_D_NACK : (ack_en_ff ? SC_ST_D_ACK : SC_ST_LAST);
              if (sample_ff || !ack_en_ff)
              begin
                state_ff     <= ST_IDLE;
                addressed_ff <= 1'b0;
              end
            end
            else if (ack_ff)
              status_ff <= gc_ff ? SC_SR_G_ACK : SC_SR_D_ACK;
            else
            begin
              status_ff    <= gc_ff ? SC_SR_G_NACK : SC_SR_D_NACK;
              state_ff     <= ST_IDLE;
              addressed_ff <= 1'b0;
            end
          end
        end
        ST_STOP_LOW:
          if (half_done)
          begin
            state_ff <= ST_STOP_HIGH;
            timer_ff <= 16'h0000;
          end
        ST_STOP_HIGH:
          if (!scl_s)
            timer_ff <= 16'h0000;
          else if (half_done)
          begin
            state_ff     <= ST_IDLE;
            end_req_ff   <= 1'b0;
            is_master_ff <= 1'b0;
          end
      endcase

      if (bus_err)
      begin
        state_ff      <= ST_IDLE;
        is_master_ff  <= 1'b0;
        addressed_ff  <= 1'b0;
        addr_phase_ff <= 1'b0;
        status_ff     <= SC_BUS_ERR;
        flag_ff       <= 1'b1;
      end
      else if (bus_cond && state_ff == ST_SLOT)
      begin
        if (addressed_ff)
        begin
          status_ff <= SC_SR_STOP;
          flag_ff   <= 1'b1;
        end
        addressed_ff  <= 1'b0;
        bit_cnt_ff    <= 4'h0;
        addr_phase_ff <= start_det;
        tx_dir_ff     <= 1'b0;
        arb_lost_ff   <= 1'b0;
        state_ff      <= start_det ? ST_SLOT : ST_IDLE;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin drive
  // ------------------------------------------------------------
  always_comb
  begin
    slot_drive = bit_cnt_ff[3] ? (~tx_dir_ff & ack_ff) : (tx_dir_ff & ~data_ff[7]);
    nxt_scl_oe = state_ff == ST_RS_LOW || state_ff == ST_LOW ||
                 state_ff == ST_HOLD || state_ff == ST_STOP_LOW;
    unique case (state_ff)
      ST_START, ST_STOP_LOW, ST_STOP_HIGH: nxt_sda_oe = 1'b1;
      ST_LOW, ST_HIGH, ST_SLOT:            nxt_sda_oe = slot_drive;
      default:                             nxt_sda_oe = 1'b0;
    endcase
  end

  // Data line moves only while clock is low, except start/stop/release
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end
    else
    begin
      scl_oe_ff <= nxt_scl_oe;
      if (!scl_s || state_ff == ST_IDLE || state_ff == ST_START)
        sda_oe_ff <= nxt_sda_oe;
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe  = scl_oe_ff;
  assign sda_oe  = sda_oe_ff;

  // ------------------------------------------------------------
  // Register readback
  // ------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (srst)
      rdata_ff <= 8'h00;
    else if (reg_rd)
      unique case (reg_addr)
        OFS_CTRL_SET: rdata_ff <= {1'b0, enable_ff, begin_req_ff, end_req_ff, flag_ff, ack_en_ff, 2'b00};
        OFS_STATUS:   rdata_ff <= status_ff;
        OFS_DATA:     rdata_ff <= data_ff;
        OFS_OWN_ADDR: rdata_ff <= own_addr_ff;
        default:      rdata_ff <= 8'h00;
      endcase
    else
      rdata_ff <= 8'h00;
  end

  assign reg_rdata = rdata_ff;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence stop_req_s;
    state_ff == ST_HOLD && is_master_ff && !flag_ff && end_req_ff;
  endsequence

  start_code_a: assert property (state_ff == ST_START && half_done && !rstart_ff && !bus_err
    |=> status_ff == SC_START && flag_ff && state_ff == ST_HOLD) else $error("start status wrong");
  bus_err_a: assert property (bus_err
    |=> status_ff == SC_BUS_ERR && flag_ff && !is_master_ff ##1 !scl_oe_ff) else $error("bus error handling");
  arb_data_a: assert property (arb_hit && !addr_phase_ff
    |=> status_ff == SC_ARB_LOST && flag_ff && !is_master_ff) else $error("arbitration loss");
  sr_nack_a: assert property (slv_end && !addr_phase_ff && !tx_dir_ff && !ack_ff && !gc_ff
    |=> status_ff == SC_SR_D_NACK && !addressed_ff) else $error("slave nack status");
  set_ack_a: assert property (reg_wr && reg_addr == OFS_CTRL_SET && reg_wdata[CB_ACK]
    |=> ack_en_ff) else $error("ack-enable not set");
  clr_flag_a: assert property (reg_wr && reg_addr == OFS_CTRL_CLR && reg_wdata[CB_FLAG]
    && state_ff == ST_HOLD |=> !flag_ff) else $error("flag not cleared");
  hold_scl_a: assert property (state_ff == ST_HOLD && flag_ff
    |=> scl_oe_ff && state_ff == ST_HOLD) else $error("clock not held");
  stop_seq_a: assert property (stop_req_s |=> state_ff == ST_STOP_LOW ##1 scl_oe_ff)
    else $error("stop not started");
  stop_done_a: assert property (state_ff == ST_STOP_HIGH && scl_s && half_done
    |=> !end_req_ff && state_ff == ST_IDLE) else $error("stop request kept");

endmodule

// >>> i2cse_slave_model.sv
// Behavioural two-wire slave that acknowledges on request
`timescale 1ns/1ps
module i2cse_slave_model
(
  // Bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  output logic            sda_oe,
  // Control and capture
  input  wire logic       ack_en,
  output logic      [7:0] rx_byte
);
  int         cnt = 0;
  logic [7:0] sh  = 8'h00;
  initial
  begin
    sda_oe  = 1'b0;
    rx_byte = 8'h00;
  end
  // Start restarts bit count
  always @(negedge sda)
  begin
    if (scl)
      cnt = 0;
  end
  always @(posedge scl)
  begin
    sh  = {sh[6:0], sda};
    cnt = cnt + 1;
  end
  // Ack slot after eighth bit
  always @(negedge scl)
  begin
    sda_oe = 1'b0;
    if (cnt == 8)
    begin
      rx_byte = sh;
      sda_oe  = ack_en;
    end
    else if (cnt == 9)
      cnt = 0;
  end
endmodule

// >>> testbench.sv
// Self-checking bench of the two-wire status engine
`timescale 1ns/1ps
module testbench;
  import i2cse_pkg::*;
  logic       core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ack_en = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rx_byte, d;
  logic       scl_out, scl_oe, sda_out, sda_oe, slv_oe;
  logic       m_scl = 1'b0, m_sda = 1'b0, mack;
  wire        scl = !(scl_oe || m_scl);
  wire        sda = !(sda_oe || slv_oe || m_sda);
  int         miscompares = 0, comparisons = 0, cycles = 0;
  always #12.5 core_clk = !core_clk;
  i2cse_core #(.HALF_CYCLES(4)) u_i2cse_core (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
  i2cse_slave_model u_i2cse_slave_model (.scl(scl), .sda(sda), .sda_oe(slv_oe), .ack_en(ack_en),
    .rx_byte(rx_byte));
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 chk($sformatf("register %h", a), reg_rdata, e);
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Bench as a second master: one bit slot, line pulled low for a 0
  task automatic mbit(input logic b, output logic s);
    @(posedge core_clk);
    m_sda <= !b;
    repeat (8) @(posedge core_clk);
    m_scl <= 1'b0;
    wait (scl);
    repeat (7) @(posedge core_clk);
    #1 s = sda;
    @(posedge core_clk);
    m_scl <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask
  // Eight bits, then a released acknowledge slot
  task automatic mbyte(input logic [7:0] v, output logic s);
    for (int i = 7; i >= 0; i--)
      mbit(v[i], s);
    mbit(1'b1, s);
  endtask
  // Poll control until masked bits match
  task automatic wait_ctl(input logic [7:0] m, input logic [7:0] e);
    d = e ^ m;
    for (int i = 0; i < 200 && (d & m) !== e; i++)
    begin
      @(posedge core_clk);
      reg_addr <= OFS_CTRL_SET;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
    end
    if ((d & m) !== e)
      miscompares++;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    rchk(OFS_STATUS, SC_IDLE);
    rchk(8'h14, 8'h00);
    wr(OFS_CTRL_SET, 8'h04);
    rchk(OFS_CTRL_SET, 8'h04);
    wr(OFS_CTRL_CLR, 8'h0C);
    rchk(OFS_CTRL_SET, 8'h00);
    wr(OFS_CTRL_SET, 8'h40);
    wr(OFS_CTRL_SET, 8'h24);
    wait_ctl(8'h08, 8'h08);
    rchk(OFS_STATUS, SC_START);
    chk("clock hold", {7'h00, scl_oe}, 8'h01);
    wr(OFS_DATA, 8'hA0);
    wr(OFS_CTRL_CLR, 8'h08);
    wait_ctl(8'h08, 8'h08);
    rchk(OFS_STATUS, SC_MT_AW_ACK);
    wr(OFS_DATA, 8'h5A);
    wr(OFS_CTRL_CLR, 8'h08);
    wait_ctl(8'h08, 8'h08);
    rchk(OFS_STATUS, SC_MT_D_ACK);
    chk("byte at slave", rx_byte, 8'h5A);
    ack_en <= 1'b0;
    wr(OFS_DATA, 8'hC3);
    wr(OFS_CTRL_CLR, 8'h08);
    wait_ctl(8'h08, 8'h08);
    rchk(OFS_STATUS, SC_MT_D_NACK);
    wr(OFS_CTRL_SET, 8'h14);
    rchk(OFS_CTRL_SET, 8'h5C);
    wr(OFS_CTRL_CLR, 8'h08);
    wait_ctl(8'h10, 8'h00);
    rchk(OFS_CTRL_SET, 8'h44);
    chk("lines after stop", {4'h0, scl_out, sda_out, scl_oe, sda_oe}, 8'h00);
    wr(OFS_CTRL_SET, 8'h20);
    wait_ctl(8'h08, 8'h08);
    wr(OFS_DATA, 8'hA0);
    wr(OFS_CTRL_CLR, 8'h08);
    wait_ctl(8'h08, 8'h08);
    rchk(OFS_STATUS, SC_MT_AW_NACK);
    wr(OFS_CTRL_SET, 8'h14);
    wr(OFS_CTRL_CLR, 8'h08);
    wait_ctl(8'h10, 8'h00);
    // Engine as addressed slave receiver
    wr(OFS_OWN_ADDR, 8'h54);
    m_sda <= 1'b1;
    repeat (8) @(posedge core_clk);
    m_scl <= 1'b1;
    mbyte(8'h54, mack);
    chk("address ack", {7'h00, mack}, 8'h00);
    wait_ctl(8'h08, 8'h08);
    rchk(OFS_STATUS, SC_SR_OWN);
    wr(OFS_CTRL_CLR, 8'h0C);
    mbyte(8'hA5, mack);
    chk("data ack", {7'h00, mack}, 8'h01);
    wait_ctl(8'h08, 8'h08);
    rchk(OFS_STATUS, SC_SR_D_NACK);
    m_sda <= 1'b1;
    repeat (8) @(posedge core_clk);
    m_scl <= 1'b0;
    repeat (8) @(posedge core_clk);
    m_sda <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("lines unaddressed", {4'h0, scl_out, sda_out, scl_oe, sda_oe}, 8'h00);
    print_verdict();
  end
endmodule
